// File: logic/serdes_spi_gpsi_defs.svh
// Purpose: Constants for the serial-peripheral and general-purpose serial link unit.
// Assumes: Bit positions of the mode and configuration words as used by the unit.
// Notes: Definitions only.
`ifndef SERDES_SPI_GPSI_DEFS_SVH
`define SERDES_SPI_GPSI_DEFS_SVH
`define CFG_MASTER_BIT 7
`define MODE_CLOCK_IDLE_POLARITY_BIT 4
`define MODE_CLOCK_SAMPLE_PHASE_BIT 3
`define MODE_SEL_LO 0
`define MODE_SEL_HI 2
`define MODE_SEL_W 3
`define MODE_SEL_SPI 3'h0
`define MODE_SEL_GPSI 3'h7
`define MODE_SEL_DIV2 3'h7
`define GPSI_MODE_WORD 8'h3f
`define GPSI_CFG_WORD 8'h50
`define DIV_W 8
`define DIV_RESET 8'h04
`define DIV_ONE 8'h01
`define DIV_ZERO 8'h00
`define BITS_W 4
`define BITS_RESET 4'h8
`define BITS_ONE 4'h1
`define BITS_ZERO 4'h0
`endif

// File: logic/serdes_spi_gpsi_pkg.sv
// Purpose: Types shared by the unit.
// Assumes: Nothing beyond the defines header.
// Notes: States change one bit per step from idle to run to done; done back to idle changes both bits.
`include "serdes_spi_gpsi_defs.svh"
package serdes_spi_gpsi_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } spi_state_t;
    typedef logic [7:0] byte_t;
endpackage

// File: logic/serdes_spi_gpsi.sv
// Purpose: Serial-peripheral master/slave and general-purpose serial link unit.
// Assumes: Configuration words are held stable while a transfer runs.
// Notes: Pins from outside pass two flip-flops before any logic reads them.
// Notes: The serial clock pin is sampled through a third flip-flop for edge detection.
// Notes: Slave select is active low and ends a slave word when it rises.
// Notes: In link mode the receive valid pin qualifies the receive data pin.
// Notes: The master holds its divider at zero while idle, so the first edge
// Notes: always comes one half period after the start has been taken.
// Notes: A master word is always eight bits, most significant bit first.
// Notes: A slave word has no bit count; it ends only when select rises.
// Notes: Pin latency of two to three cycles limits the slave clock rate to
// Notes: well below one eighth of the system clock.
// Notes: Mode and configuration changes during a word are not supported.
//
// Overview of operation
// (R1) Receive config bit 7 selects slave or master.
// (R2) Serial clock idles at polarity level when deselected.
// (R3) Phase 0 slave samples on first edge.
// (R4) Phase 0 partner presents data half period early.
// (R5) Phase 1 slave samples on second edge.
// (R6) Phase 1 partner changes data on first edge.
// (R7) First edge rising for polarity 0, else falling.
// (R8) Drive and sample on opposite clock edges.
// (R9) Polarity/phase table picks drive and sample edges.
// (R10) Deselected slave drives output latch value.
// (R11) Clock pin output as master, input as slave.
// (R12) Slave select input as slave, software pin as master.
// (R13) Link is point-to-point full duplex, two devices.
// (R14) PHY party drives two running clocks.
// (R15) Link data and valid follow their clock.
// (R16) Collision and busy are software pins only.
// (R17) No new transfer while partner is busy.
// (R18) Link master outputs one clock on transmit-minus.
// (R19) Link master drives data/valid, accepts receive pair.
// (R20) Mode 63, configs 80 give divided-by-two clock.
// (R21) Master clock toggles only during a transfer.
`timescale 1ns/1ps
module serdes_spi_gpsi
    import serdes_spi_gpsi_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Configuration words.
    input wire serdes_spi_gpsi_pkg::byte_t unit_mode_reg,
    input wire serdes_spi_gpsi_pkg::byte_t rx_config_reg,
    input wire serdes_spi_gpsi_pkg::byte_t tx_config_reg,
    input wire logic [`DIV_W-1:0] clk_div_half,
    input wire logic port_output_latch,
    // Software transfer port.
    input wire logic tx_start,
    input wire serdes_spi_gpsi_pkg::byte_t tx_word,
    output logic rx_done_q,
    output serdes_spi_gpsi_pkg::byte_t rx_word_q,
    output logic busy_q,
    // Serial clock pin, three signals.
    input wire logic unit_clock_pin_in,
    output logic unit_clock_pin_out_q,
    output logic unit_clock_pin_oe_q,
    // Slave select and data pins.
    input wire logic rx_plus_pin,
    input wire logic rx_data_pin,
    output logic tx_plus_pin_q,
    output logic tx_output_enable_pin_q,
    output logic tx_minus_pin_q,
    // Flow-control pins seen by software.
    input wire logic link_busy_flag,
    output logic link_busy_seen_q
);
    import serdes_spi_gpsi_pkg::*;

    logic is_master;
    logic clock_idle_polarity;
    logic clock_sample_phase;
    logic gpsi_sel;
    logic div2_sel;
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic ss_s1_q, ss_s2_q;
    logic rxd_s1_q, rxd_s2_q;
    logic rxv_s1_q, rxv_s2_q;
    logic bsy_s1_q, bsy_s2_q;
    logic sck_rise, sck_fall, lead_edge, trail_edge;
    logic sample_on_rise;
    logic slave_sel;
    logic ss_prev_q;
    spi_state_t state_q;
    logic [`DIV_W-1:0] div_cnt_q;
    logic half_tick;
    logic [`BITS_W-1:0] bits_q;
    byte_t tx_sh_q, rx_sh_q;
    logic first_q;
    logic link_clk_q;
    logic link_rise;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode.
    // The role and the edge table come straight from the configuration words.
    // Nothing here is registered, so a change takes effect at the next edge.
    assign is_master = rx_config_reg[`CFG_MASTER_BIT]; // R1
    assign clock_idle_polarity = unit_mode_reg[`MODE_CLOCK_IDLE_POLARITY_BIT];
    assign clock_sample_phase = unit_mode_reg[`MODE_CLOCK_SAMPLE_PHASE_BIT];
    assign gpsi_sel = (unit_mode_reg == `GPSI_MODE_WORD); // R13
    assign div2_sel = gpsi_sel && (rx_config_reg == `GPSI_CFG_WORD)
        && (tx_config_reg == `GPSI_CFG_WORD); // R20
    // Sample edge is rising for 0/0 and 1/1, falling otherwise.
    assign sample_on_rise = (clock_idle_polarity == clock_sample_phase); // R9 R8

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every pin input.
    // Every pin comes from another clock domain, so no logic reads the first stage.
    // Select resets to its inactive high level to avoid a false start after reset.
    // The third clock stage only feeds the edge detector below.
    // Receive valid shares its pin with slave select but has its own stages.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
            rxd_s1_q <= 1'b0;
            rxd_s2_q <= 1'b0;
            rxv_s1_q <= 1'b0;
            rxv_s2_q <= 1'b0;
            bsy_s1_q <= 1'b0;
            bsy_s2_q <= 1'b0;
        end else begin
            sck_s1_q <= unit_clock_pin_in; // R11
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            ss_s1_q <= rx_plus_pin; // R12
            ss_s2_q <= ss_s1_q;
            rxd_s1_q <= rx_data_pin;
            rxd_s2_q <= rxd_s1_q;
            rxv_s1_q <= rx_plus_pin;
            rxv_s2_q <= rxv_s1_q;
            bsy_s1_q <= link_busy_flag;
            bsy_s2_q <= bsy_s1_q;
        end
    end

    // Slave select is active low; edges come from the synchronised clock.
    // A slave is only selected outside link mode and outside master role.
    // Edges are found by comparing the second and third clock stages.
    assign slave_sel = !is_master && !gpsi_sel && !ss_s2_q; // R12
    assign sck_rise = sck_s2_q && !sck_s3_q;
    assign sck_fall = !sck_s2_q && sck_s3_q;
    // First edge is rising when idle is low, falling when idle is high.
    assign lead_edge = clock_idle_polarity ? sck_fall : sck_rise; // R7
    assign trail_edge = clock_idle_polarity ? sck_rise : sck_fall;

    ////////////////////////////////////////////////////////////////////////
    // Half-period divider for master clock and link clock.
    // One enable pulse per half period; a setting of zero or one ticks every cycle.
    // Divided-by-two link mode forces a tick on every cycle.
    // Holding the count while idle gives the partner a half period of setup.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_cnt_q <= `DIV_ZERO;
        end else if (state_q == ST_IDLE && !gpsi_sel) begin
            // Restart the half period so the first bit is set up early.
            div_cnt_q <= `DIV_ZERO; // R4 R21
        end else if (half_tick) begin
            div_cnt_q <= `DIV_ZERO;
        end else begin
            div_cnt_q <= div_cnt_q + `DIV_ONE;
        end
    end
    assign half_tick = div2_sel || (div_cnt_q + `DIV_ONE >= clk_div_half)
        || (clk_div_half == `DIV_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer shared by master and slave roles.
    // The master counts eight sampling edges and then finishes its word.
    // The slave follows the synchronised clock until select goes inactive.
    // The first leading edge in phase one only starts the word, with no shift.
    // A start request is refused while the partner reports busy.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bits_q <= `BITS_ZERO;
            tx_sh_q <= 8'h00;
            rx_sh_q <= 8'h00;
            first_q <= 1'b0;
            unit_clock_pin_out_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else begin
            ss_prev_q <= ss_s2_q;
            unique case (state_q)
                ST_IDLE: begin
                    unit_clock_pin_out_q <= clock_idle_polarity; // R2 R21
                    bits_q <= `BITS_RESET;
                    first_q <= 1'b1;
                    // Master waits for software; busy partner blocks it.
                    if (is_master && !gpsi_sel && tx_start && !bsy_s2_q) begin // R17
                        tx_sh_q <= tx_word;
                        state_q <= ST_RUN;
                    end else if (slave_sel && ss_prev_q) begin
                        tx_sh_q <= tx_word;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (is_master) begin
                        if (half_tick) begin
                            unit_clock_pin_out_q <= !unit_clock_pin_out_q; // R21
                            // Toggling away from idle is the first edge.
                            if (unit_clock_pin_out_q == clock_idle_polarity) begin
                                if (!clock_sample_phase) begin
                                    rx_sh_q <= {rx_sh_q[6:0], rxd_s2_q};
                                    bits_q <= bits_q - `BITS_ONE;
                                end else if (!first_q) begin
                                    tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                end
                                first_q <= 1'b0;
                            end else begin
                                if (clock_sample_phase) begin
                                    rx_sh_q <= {rx_sh_q[6:0], rxd_s2_q};
                                    bits_q <= bits_q - `BITS_ONE;
                                end else begin
                                    tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                end
                                // Phase one samples here, so its last bit is still counted.
                                if ((clock_sample_phase && bits_q == `BITS_ONE) || (!clock_sample_phase && bits_q == `BITS_ZERO)) begin
                                    state_q <= ST_DONE;
                                end
                            end
                        end
                    end else if (!slave_sel) begin
                        state_q <= ST_DONE;
                    end else if (lead_edge) begin
                        if (!clock_sample_phase) begin
                            rx_sh_q <= {rx_sh_q[6:0], rxd_s2_q}; // R3 R4
                            bits_q <= bits_q - `BITS_ONE;
                        end else if (!first_q) begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0}; // R6
                        end
                        first_q <= 1'b0;
                    end else if (trail_edge) begin
                        if (clock_sample_phase) begin
                            rx_sh_q <= {rx_sh_q[6:0], rxd_s2_q}; // R5
                            bits_q <= bits_q - `BITS_ONE;
                        end else begin
                            tx_sh_q <= {tx_sh_q[6:0], 1'b0}; // R8
                        end
                    end
                end
                ST_DONE: begin
                    unit_clock_pin_out_q <= clock_idle_polarity; // R21
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-visible results.
    // The done pulse and the received word appear together one cycle after done.
    // In link mode each valid bit is shifted into the received word on the link edge.
    // Busy covers the whole word from the cycle after the start.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_done_q <= 1'b0;
            rx_word_q <= 8'h00;
            busy_q <= 1'b0;
            link_busy_seen_q <= 1'b0;
        end else begin
            rx_done_q <= (state_q == ST_DONE);
            if (state_q == ST_DONE) begin
                rx_word_q <= rx_sh_q;
            end else if (link_rise && rxv_s2_q) begin
                // Receive pair is taken only while its valid is high.
                rx_word_q <= {rx_word_q[6:0], rxd_s2_q}; // R19 R15
            end
            busy_q <= (state_q != ST_IDLE);
            link_busy_seen_q <= bsy_s2_q; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link clock on transmit-minus and link data on its rising edge.
    // The clock runs freely in link mode, as a link clock must.
    // The same clock serves the partner for both directions.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            link_clk_q <= 1'b0;
        end else if (gpsi_sel && half_tick) begin
            link_clk_q <= !link_clk_q; // R18 R20 R14
        end
    end
    assign link_rise = gpsi_sel && half_tick && !link_clk_q;

    // Pin drivers for both modes.
    // Data follows the shift register one cycle later, away from the sampling edge.
    // A deselected slave shows the output latch level instead of its data.
    // The clock pin is only driven in master role outside link mode.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_plus_pin_q <= 1'b0;
            tx_output_enable_pin_q <= 1'b0;
            tx_minus_pin_q <= 1'b0;
            unit_clock_pin_oe_q <= 1'b0;
        end else begin
            tx_minus_pin_q <= link_clk_q; // R18
            unit_clock_pin_oe_q <= is_master && !gpsi_sel; // R11
            if (gpsi_sel) begin
                if (link_rise) begin
                    tx_plus_pin_q <= tx_word[7]; // R15 R19
                    tx_output_enable_pin_q <= tx_start; // R19
                end
            end else begin
                tx_output_enable_pin_q <= 1'b0;
                if (state_q == ST_RUN) begin
                    tx_plus_pin_q <= tx_sh_q[7]; // R8
                end else if (!is_master) begin
                    tx_plus_pin_q <= port_output_latch; // R10
                end else begin
                    tx_plus_pin_q <= tx_sh_q[7];
                end
            end
        end
    end
endmodule // serdes_spi_gpsi

// File: dv/serdes_spi_gpsi_checker.sv
// Purpose: Port-level checks for the serial-peripheral and serial link unit.
// Assumes: Only the top-level ports are visible.
// Notes: History from reset is ignored until seven settled cycles have passed.
`timescale 1ns/1ps
module serdes_spi_gpsi_checker
    import serdes_spi_gpsi_pkg::*;
(
    // Clock, reset and configuration.
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire serdes_spi_gpsi_pkg::byte_t unit_mode_reg,
    input wire serdes_spi_gpsi_pkg::byte_t rx_config_reg,
    input wire serdes_spi_gpsi_pkg::byte_t tx_config_reg,
    input wire logic port_output_latch,
    input wire logic tx_start,
    input wire logic rx_plus_pin,
    input wire logic link_busy_flag,
    // Observed outputs.
    input wire logic busy_q,
    input wire logic unit_clock_pin_out_q,
    input wire logic unit_clock_pin_oe_q,
    input wire logic tx_plus_pin_q,
    input wire logic tx_output_enable_pin_q,
    input wire logic tx_minus_pin_q,
    input wire logic link_busy_seen_q
);
    logic [2:0] up_q;
    logic ok, lnk, mst, d2;
    // Counts settled cycles since reset so that stale history never counts.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    // Decoded modes.
    assign ok = (up_q == 3'h7);
    assign lnk = (unit_mode_reg == 8'h3f);
    assign mst = rx_config_reg[7] && !lnk;
    assign d2 = lnk && rx_config_reg == 8'h50 && tx_config_reg == 8'h50;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_desel;
        (ok && !mst && !lnk && rx_plus_pin && $stable(port_output_latch))[*6];
    endsequence
    sequence s_busy_held;
        (ok && link_busy_flag)[*4];
    endsequence
    property p_oe;
        (ok && $stable(unit_mode_reg) && $stable(rx_config_reg))[*2] |-> unit_clock_pin_oe_q == mst;
    endproperty
    property p_idle;
        (ok && !lnk && !busy_q && $stable(unit_mode_reg))[*2]
            |-> unit_clock_pin_out_q == unit_mode_reg[4];
    endproperty
    property p_drive;
        ok && mst && busy_q && $past(busy_q) && $changed(tx_plus_pin_q)
            |-> unit_clock_pin_out_q == (unit_mode_reg[4] ^ unit_mode_reg[3]);
    endproperty
    property p_desel;
        s_desel |-> tx_plus_pin_q == port_output_latch;
    endproperty
    property p_div2;
        (ok && d2)[*4] |-> tx_minus_pin_q != $past(tx_minus_pin_q);
    endproperty
    property p_seen;
        (ok && $stable(link_busy_flag))[*4] |-> link_busy_seen_q == link_busy_flag;
    endproperty
    property p_refuse;
        s_busy_held ##0 (mst && !busy_q) |=> !busy_q;
    endproperty
    property p_lvalid;
        (ok && d2 && tx_start)[*8] |-> tx_output_enable_pin_q;
    endproperty
    a_oe: assert property (p_oe) else $error("clock pin enable wrong for role");
    a_idle: assert property (p_idle) else $error("serial clock not at idle level");
    a_drive: assert property (p_drive) else $error("data changed on sampling edge");
    a_desel: assert property (p_desel) else $error("deselected output not latch");
    a_div2: assert property (p_div2) else $error("link clock not half rate");
    a_seen: assert property (p_seen) else $error("busy flag copy wrong");
    a_refuse: assert property (p_refuse) else $error("start taken while busy");
    a_lvalid: assert property (p_lvalid) else $error("link valid not driven");
endmodule // serdes_spi_gpsi_checker
bind serdes_spi_gpsi serdes_spi_gpsi_checker u_chk (.*);

// File: dv/spi_peer_model.sv
// Purpose: Serial-peripheral device facing the unit in master role.
// Assumes: Select and mode bits come from the bench.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ps
module spi_peer_model (
    // Serial lines, mode and data.
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic clock_idle_polarity,
    input wire logic clock_sample_phase,
    input wire logic [7:0] load_byte,
    output logic miso = 1'b0,
    output logic [7:0] got_byte = 8'h00
);
    logic [7:0] sh = 8'h00;
    // Phase 0 sets up the first bit before the first clock edge.
    always @(negedge sel_n) begin
        sh = clock_sample_phase ? load_byte : {load_byte[6:0], 1'b0};
        if (!clock_sample_phase) miso = load_byte[7];
    end
    // A released line goes to the inverse of its last value.
    always @(posedge sel_n) miso = !miso;
    // Leading edge drives when phase is 1, trailing edge when phase is 0.
    always @(sclk) begin
        if (!sel_n && ((sclk != clock_idle_polarity) == clock_sample_phase)) begin
            miso = sh[7];
            sh = {sh[6:0], 1'b0};
        end else if (!sel_n) begin
            got_byte = {got_byte[6:0], mosi};
        end
    end
endmodule // spi_peer_model

// File: dv/serdes_spi_gpsi_tb.sv
// Purpose: Self-checking bench for the serial unit.
// Assumes: 100 MHz clock, half serial period of six cycles.
// Notes: Master words run against a peer model; slave words are bit-banged.
`timescale 1ns/1ps
module serdes_spi_gpsi_tb
    import serdes_spi_gpsi_pkg::*;
;
    logic clk_sys, sys_rst, port_output_latch, tx_start, rx_done_q, busy_q, unit_clock_pin_in;
    logic unit_clock_pin_out_q, unit_clock_pin_oe_q, rx_plus_pin, rx_data_pin, tx_plus_pin_q;
    logic tx_output_enable_pin_q, tx_minus_pin_q, link_busy_flag, link_busy_seen_q, sdi, miso, slv;
    byte_t unit_mode_reg, rx_config_reg, tx_config_reg, tx_word, rx_word_q, peer_byte, peer_got;
    logic [7:0] clk_div_half;
    int errors = 0, n_checks = 0, cyc = 0, dones = 0, i;
    assign rx_data_pin = slv ? sdi : miso;
    serdes_spi_gpsi DUT (.*);
    spi_peer_model peer (.sclk(unit_clock_pin_out_q), .sel_n(rx_plus_pin), .mosi(tx_plus_pin_q),
        .clock_idle_polarity(unit_mode_reg[4]), .clock_sample_phase(unit_mode_reg[3]), .load_byte(peer_byte),
        .miso(miso), .got_byte(peer_got));
    // Free-running clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counts done pulses and cuts a hang short.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        dones <= dones + (rx_done_q === 1'b1);
        if (cyc == 5000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One master word: both directions, toggle count and idle level.
    task automatic master_xfer(input logic [1:0] m, input byte_t v, input byte_t w);
        int n = 0, e = 0, d0;
        logic prev;
        slv = 1'b0;
        unit_mode_reg = {3'h0, m, 3'h0};
        rx_config_reg = 8'h80;
        tx_word = v;
        peer_byte = w;
        tick(4);
        chk(unit_clock_pin_out_q, m[1]);
        chk(unit_clock_pin_oe_q, 1'b1);
        rx_plus_pin = 1'b0;
        tick(2);
        d0 = dones;
        prev = m[1];
        tx_start = 1'b1;
        tick(1);
        tx_start = 1'b0;
        tick(1);
        while (busy_q !== 1'b0 && n < 300) begin
            tick(1);
            n++;
            e += (unit_clock_pin_out_q !== prev);
            prev = unit_clock_pin_out_q;
        end
        tick(3);
        rx_plus_pin = 1'b1;
        chk(8'(e), 8'h10);
        chk(unit_clock_pin_out_q, m[1]);
        chk(rx_word_q, w);
        chk(peer_got, v);
        chk(8'(dones - d0), 8'h01);
    endtask
    // One slave word clocked by the bench, with the deselected output level.
    task automatic slave_xfer(input logic [1:0] m, input byte_t v);
        int k;
        slv = 1'b1;
        unit_mode_reg = {3'h0, m, 3'h0};
        rx_config_reg = 8'h00;
        unit_clock_pin_in = m[1];
        port_output_latch = !v[0];
        tick(6);
        chk(tx_plus_pin_q, !v[0]);
        chk(unit_clock_pin_oe_q, 1'b0);
        rx_plus_pin = 1'b0;
        for (k = 7; k >= 0; k--) begin
            if (!m[0]) sdi = v[k];
            tick(6);
            unit_clock_pin_in = !unit_clock_pin_in;
            if (m[0]) sdi = v[k];
            tick(6);
            unit_clock_pin_in = !unit_clock_pin_in;
        end
        tick(6);
        rx_plus_pin = 1'b1;
        sdi = !sdi;
        tick(6);
        chk(rx_word_q, v);
    endtask
    // A start while the partner is busy is ignored.
    task automatic busy_refuse();
        unit_mode_reg = 8'h00;
        rx_config_reg = 8'h80;
        link_busy_flag = 1'b1;
        tick(5);
        chk(link_busy_seen_q, 1'b1);
        tx_start = 1'b1;
        tick(1);
        tx_start = 1'b0;
        tick(3);
        chk(busy_q, 1'b0);
        link_busy_flag = 1'b0;
        tick(5);
        chk(link_busy_seen_q, 1'b0);
    endtask
    // Link mode at half rate with valid and data driven.
    task automatic link_mode();
        int k;
        logic prev;
        unit_mode_reg = 8'h3f;
        rx_config_reg = 8'h50;
        tx_config_reg = 8'h50;
        tx_word = 8'h80;
        slv = 1'b1;
        sdi = 1'b1;
        tx_start = 1'b1;
        tick(8);
        chk(tx_output_enable_pin_q, 1'b1);
        chk(tx_plus_pin_q, 1'b1);
        for (k = 0; k < 6; k++) begin
            prev = tx_minus_pin_q;
            tick(1);
            chk(tx_minus_pin_q, !prev);
        end
        tx_start = 1'b0;
        tick(8);
        chk(tx_output_enable_pin_q, 1'b0);
        chk(rx_word_q, 8'hff);
    endtask
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        {port_output_latch, tx_start, unit_clock_pin_in, link_busy_flag, sdi, slv} = 6'h00;
        rx_plus_pin = 1'b1;
        {unit_mode_reg, rx_config_reg, tx_config_reg, tx_word, peer_byte} = 40'h0;
        clk_div_half = 8'h06;
        tick(5);
        sys_rst = 1'b0;
        tick(4);
        for (i = 0; i < 4; i++) master_xfer(2'(i), 8'h81 ^ 8'(i), 8'h7e ^ 8'(i));
        for (i = 0; i < 4; i++) slave_xfer(2'(i), 8'hc3 ^ 8'(i));
        busy_refuse();
        link_mode();
        tally_and_finish();
    end
endmodule // serdes_spi_gpsi_tb
